// file: hw/addr_modifier.v
// Effective-address generation: tag decode, indexing, indirection, tally,
// and relocation of every memory address in the unprivileged mode.
// Assumes a memory that answers one read or read-alter-rewrite at a time.
`timescale 1ns/1ns
`default_nettype none
`include "addr_mod_regs.vh"

module addr_modifier #(
    parameter AW = 18,
    parameter DW = 36
) (
    input wire clk,
    input wire rst_n,
    input wire start,
    input wire [DW-1:0] instr_word,
    input wire is_repeat,
    input wire privileged,
    input wire [AW-1:0] instruction_counter,
    input wire [DW-1:0] acc,
    input wire [DW-1:0] quot,
    input wire idx_we,
    input wire [2:0] idx_waddr,
    input wire [AW-1:0] idx_wdata,
    input wire load_base_instruction,
    input wire [AW-1:0] base_wdata,
    input wire mem_ack,
    input wire [DW-1:0] mem_rdata,
    output reg mem_req,
    output reg mem_rar,
    output reg [AW-1:0] mem_addr,
    output reg [DW-1:0] mem_wdata,
    output reg done,
    output reg [AW-1:0] eff_addr,
    output reg direct_valid,
    output reg [DW-1:0] direct_operand,
    output reg [2:0] char_pos,
    output reg tally_runout,
    output reg tag_fault,
    output reg busy,
    output reg [AW-1:0] relocation_base
);
    localparam S_IDLE = 3'h0;
    localparam S_MOD = 3'h1;
    localparam S_IDXW = 3'h2;
    localparam S_FETCH = 3'h3;
    localparam S_WAIT = 3'h4;
    localparam S_RAR = 3'h5;
    localparam S_IDX2 = 3'h6;

    reg [2:0] state_r;
    reg [AW-1:0] y_r;
    reg [1:0] tm_r;
    reg [3:0] td_r;
    reg [3:0] final_td_r;
    reg final_pend_r;
    reg tally_mode_r;
    reg [3:0] tally_td_r;
    reg [DW-1:0] ind_r;
    reg [3:0] idx_td_r;
    reg [1:0] after_r;
    wire [AW-1:0] idx_rdata;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function [AW-1:0] relocate;
        input [AW-1:0] a;
        input [AW-1:0] base;
        input priv;
        reg [8:0] hi;
        begin
            hi = a[AW-1:AW-9] + base[AW-1:AW-9];
            relocate = priv ? a : {hi, a[AW-10:0]};
        end
    endfunction

    function [AW-1:0] index_add;
        input [AW-1:0] y;
        input [3:0] td;
        input [AW-1:0] xr;
        input [AW-1:0] ic;
        input [DW-1:0] a;
        input [DW-1:0] q;
        begin
            case (td)
                `TD_AU: index_add = y + a[DW-1:AW];
                `TD_AL: index_add = y + a[AW-1:0];
                `TD_QU: index_add = y + q[DW-1:AW];
                `TD_QL: index_add = y + a[AW-1:0];
                `TD_IC: index_add = y + ic;
                default: index_add = td[3] ? y + xr : y;
            endcase
        end
    endfunction

    index_file #(.WIDTH(AW), .DEPTH(8), .AW(3)) u_idx (
        .clk(clk),
        .we(idx_we),
        .waddr(idx_waddr),
        .wdata(idx_wdata),
        .raddr(idx_td_r[2:0]),
        .rdata(idx_rdata)
    );

    wire [1:0] ind_tm = ind_r[5:4];
    wire [3:0] ind_td = ind_r[3:0];
    wire [AW-1:0] ind_y = ind_r[DW-1:AW];
    wire [11:0] ind_tally = ind_r[17:6];
    wire [2:0] ind_cf = ind_r[2:0];
    wire [5:0] ind_delta = ind_r[5:0];

    // ----------------------------------------
    // Base register
    // ----------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            relocation_base <= `BASE_RESET;
        end else if (load_base_instruction) begin
            relocation_base <= base_wdata & `BASE_FIXED_MASK;
        end
    end

    // ----------------------------------------
    // Modification sequencer
    // ----------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            state_r <= S_IDLE;
            y_r <= {AW{1'b0}};
            tm_r <= 2'h0;
            td_r <= 4'h0;
            final_td_r <= 4'h0;
            final_pend_r <= 1'b0;
            tally_mode_r <= 1'b0;
            tally_td_r <= 4'h0;
            ind_r <= {DW{1'b0}};
            idx_td_r <= 4'h0;
            after_r <= 2'h0;
            mem_req <= 1'b0;
            mem_rar <= 1'b0;
            mem_addr <= {AW{1'b0}};
            mem_wdata <= {DW{1'b0}};
            done <= 1'b0;
            eff_addr <= {AW{1'b0}};
            direct_valid <= 1'b0;
            direct_operand <= {DW{1'b0}};
            char_pos <= 3'h0;
            tally_runout <= 1'b0;
            tag_fault <= 1'b0;
            busy <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    if (start) begin
                        y_r <= instr_word[DW-1:AW];
                        tm_r <= instr_word[5:4];
                        td_r <= instr_word[3:0];
                        final_pend_r <= 1'b0;
                        tally_mode_r <= 1'b0;
                        direct_valid <= 1'b0;
                        tag_fault <= 1'b0;
                        busy <= 1'b1;
                        if (is_repeat) begin
                            eff_addr <= relocate(instr_word[DW-1:AW],
                                relocation_base, privileged);
                            done <= 1'b1;
                            busy <= 1'b0;
                        end else begin
                            state_r <= S_MOD;
                        end
                    end
                end
                S_MOD: begin
                    idx_td_r <= td_r;
                    case (tm_r)
                        `TM_REG: begin
                            // IR pending: apply final designator instead
                            if (final_pend_r) begin
                                idx_td_r <= final_td_r;
                            end
                            after_r <= 2'h0;
                            state_r <= S_IDXW;
                        end
                        `TM_REG_IND: begin
                            if (td_r == `TD_DU || td_r == `TD_DL) begin
                                idx_td_r <= `TD_NONE;
                            end
                            after_r <= 2'h1;
                            state_r <= S_IDXW;
                        end
                        `TM_IND_REG: begin
                            final_td_r <= td_r;
                            final_pend_r <= 1'b1;
                            state_r <= S_FETCH;
                        end
                        default: begin
                            tally_mode_r <= 1'b1;
                            tally_td_r <= td_r;
                            if (td_r == `TY_FAULT) begin
                                tag_fault <= 1'b1;
                                done <= 1'b1;
                                busy <= 1'b0;
                                state_r <= S_IDLE;
                            end else begin
                                state_r <= S_FETCH;
                            end
                        end
                    endcase
                end
                S_IDXW: begin
                    state_r <= S_IDX2;
                end
                S_IDX2: begin
                    if (after_r == 2'h1) begin
                        y_r <= index_add(y_r, idx_td_r, idx_rdata,
                            instruction_counter, acc, quot);
                        state_r <= S_FETCH;
                    end else if (idx_td_r == `TD_DU) begin
                        direct_operand <= {y_r, {AW{1'b0}}};
                        direct_valid <= 1'b1;
                        eff_addr <= y_r;
                        done <= 1'b1;
                        busy <= 1'b0;
                        state_r <= S_IDLE;
                    end else if (idx_td_r == `TD_DL) begin
                        direct_operand <= {{AW{1'b0}}, y_r};
                        direct_valid <= 1'b1;
                        eff_addr <= y_r;
                        done <= 1'b1;
                        busy <= 1'b0;
                        state_r <= S_IDLE;
                    end else begin
                        eff_addr <= relocate(index_add(y_r, idx_td_r, idx_rdata,
                            instruction_counter, acc, quot),
                            relocation_base, privileged);
                        done <= 1'b1;
                        busy <= 1'b0;
                        state_r <= S_IDLE;
                    end
                end
                S_FETCH: begin
                    mem_req <= 1'b1;
                    mem_addr <= relocate(y_r, relocation_base, privileged);
                    mem_rar <= tally_mode_r && tally_td_r != `TY_IND
                        && tally_td_r != `TY_CHAR_PTR;
                    state_r <= S_WAIT;
                end
                S_WAIT: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        mem_rar <= 1'b0;
                        ind_r <= mem_rdata;
                        state_r <= tally_mode_r ? S_RAR : S_MOD;
                        if (!tally_mode_r) begin
                            y_r <= mem_rdata[DW-1:AW];
                            tm_r <= mem_rdata[5:4];
                            td_r <= mem_rdata[3:0];
                        end
                    end
                end
                S_RAR: begin
                    // Alter portion; rewrite travels with the done pulse, except for TY_DIC and TY_IDC, which hold done low and continue
                    tally_mode_r <= 1'b0;
                    eff_addr <= relocate(ind_y, relocation_base, privileged);
                    mem_wdata <= ind_r;
                    state_r <= S_IDLE;
                    done <= 1'b1;
                    busy <= 1'b0;
                    case (tally_td_r)
                        `TY_IND: begin
                            y_r <= ind_y;
                        end
                        `TY_CHAR_PTR: begin
                            char_pos <= ind_cf;
                        end
                        `TY_SEQ_CHAR: begin
                            char_pos <= ind_cf;
                            mem_wdata[17:6] <= ind_tally - 12'h001;
                            tally_runout <= (ind_tally == 12'h001);
                            if (ind_cf + 3'h1 == `CHAR_WRAP) begin
                                mem_wdata[2:0] <= 3'h0;
                                mem_wdata[DW-1:AW] <= ind_y + 18'h00001;
                            end else begin
                                mem_wdata[2:0] <= ind_cf + 3'h1;
                            end
                        end
                        `TY_ADD_DELTA: begin
                            mem_wdata[DW-1:AW] <= ind_y + {12'h000, ind_delta};
                            mem_wdata[17:6] <= ind_tally - 12'h001;
                            tally_runout <= (ind_tally == 12'h001);
                        end
                        `TY_DI, `TY_DIC: begin
                            mem_wdata[DW-1:AW] <= ind_y - 18'h00001;
                            mem_wdata[17:6] <= ind_tally + 12'h001;
                            tally_runout <= (ind_tally == 12'hFFF);
                            eff_addr <= relocate(ind_y - 18'h00001,
                                relocation_base, privileged);
                        end
                        default: begin
                            mem_wdata[DW-1:AW] <= ind_y + 18'h00001;
                            mem_wdata[17:6] <= ind_tally - 12'h001;
                            tally_runout <= (ind_tally == 12'h001);
                        end
                    endcase
                    if (tally_td_r == `TY_DIC || tally_td_r == `TY_IDC) begin
                        // Continue from the indirect word's tag
                        y_r <= (tally_td_r == `TY_DIC) ? ind_y - 18'h00001 : ind_y;
                        tm_r <= ind_tm;
                        td_r <= ind_td;
                        tally_td_r <= ind_td;
                        done <= 1'b0;
                        busy <= 1'b1;
                        state_r <= S_MOD;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end
endmodule

`default_nettype wire

// file: hw/addr_mod_regs.vh
// Constants for the address relocation and tag modifier.
// Assumes 36-bit words, bit 0 the least significant.
`ifndef ADDR_MOD_REGS_VH
`define ADDR_MOD_REGS_VH

// ----------------------------------------
// Modifier types
// ----------------------------------------
`define TM_REG 2'h0
`define TM_REG_IND 2'h1
`define TM_IND_TALLY 2'h2
`define TM_IND_REG 2'h3

// ----------------------------------------
// Register designators
// ----------------------------------------
`define TD_NONE 4'h0
`define TD_AU 4'h1
`define TD_QU 4'h2
`define TD_DU 4'h3
`define TD_IC 4'h4
`define TD_AL 4'h5
`define TD_QL 4'h6
`define TD_DL 4'h7

// ----------------------------------------
// Tally designators
// ----------------------------------------
`define TY_FAULT 4'h0
`define TY_CHAR_PTR 4'h8
`define TY_IND 4'h9
`define TY_SEQ_CHAR 4'hA
`define TY_ADD_DELTA 4'hB
`define TY_DI 4'hC
`define TY_DIC 4'hD
`define TY_ID 4'hE
`define TY_IDC 4'hF

// ----------------------------------------
// Word fields and base register
// ----------------------------------------
`define CHAR_WRAP 3'h6
`define BASE_FIXED_MASK 18'h3FDFE
`define BASE_RESET 18'h00000

`endif

// file: hw/index_file.v
// Eight index registers of 18 bits with registered read data.
// Assumes one clock; write and read may share a cycle.
`timescale 1ns/1ns
`default_nettype none

module index_file #(
    parameter WIDTH = 18,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk,
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [WIDTH-1:0] wdata,
    input wire [AW-1:0] raddr,
    output reg [WIDTH-1:0] rdata
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];

    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

`default_nettype wire

// file: testbench/addr_mod_asserts.sv
// Port assertions for the address modifier.
// Assumes it is bound to addr_modifier; one clock, synchronous low reset.
`timescale 1ns/1ns
`default_nettype none

module addr_mod_asserts #(
    parameter AW = 18,
    parameter DW = 36
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [DW-1:0] instr_word,
    input wire logic is_repeat,
    input wire logic busy,
    input wire logic done,
    input wire logic mem_req,
    input wire logic mem_ack,
    input wire logic mem_rar,
    input wire logic [AW-1:0] mem_addr,
    input wire logic tag_fault,
    input wire logic load_base_instruction,
    input wire logic [AW-1:0] base_wdata,
    input wire logic [AW-1:0] relocation_base
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_req_held:
    assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("memory request dropped or moved before its answer");
    chk_rar_in_req:
    assert property (mem_rar |-> mem_req)
        else $error("rewrite cycle flag without a request");
    chk_repeat_no_mem:
    assert property (start && !busy && is_repeat |=> !mem_req [*4])
        else $error("repeat instruction went to memory");
    chk_reg_type_end:
    assert property (start && !busy && !is_repeat && instr_word[5:4] == 2'h0
        |-> (!mem_req throughout (##[1:8] done)))
        else $error("register type did not end without memory");
    chk_base_fixed:
    assert property (relocation_base[9] == 1'b0 && relocation_base[0] == 1'b0)
        else $error("fixed base bits not zero");
    chk_base_load:
    assert property (load_base_instruction
        |=> relocation_base == ($past(base_wdata) & 18'h3FDFE))
        else $error("base load wrong");
    chk_fault_holds:
    assert property (tag_fault && !start |=> tag_fault)
        else $error("fault flag cleared without a start");
    chk_start_busy:
    assert property (start && !busy |=> busy ^ done)
        else $error("start not taken");
    chk_req_in_busy:
    assert property ($rose(mem_req) |-> busy)
        else $error("memory request outside a modification");
endmodule

bind addr_modifier addr_mod_asserts #(.AW(AW), .DW(DW)) i_chk (
    .clk, .rst_n, .start, .instr_word, .is_repeat, .busy, .done, .mem_req,
    .mem_ack, .mem_rar, .mem_addr, .tag_fault, .load_base_instruction,
    .base_wdata, .relocation_base
);
`default_nettype wire

// file: testbench/mem_model.sv
// Memory partner: one read or read-alter-rewrite at a time.
// Assumes requests held until the one-cycle answer.
`timescale 1ns/1ns
`default_nettype none

module mem_model (
    input wire logic clk,
    input wire logic req,
    input wire logic read_alter_rewrite_cycle,
    input wire logic [17:0] addr,
    input wire logic [3:0] lat,
    output var logic ack,
    output var logic [35:0] rdata,
    output var int n_req,
    output var logic [17:0] last_addr,
    output var logic rar_seen
);
    logic [35:0] mem [int];
    int cnt;

    initial begin
        ack = 0;
        rdata = 0;
        n_req = 0;
        last_addr = 0;
        rar_seen = 0;
        cnt = 0;
    end

    // ----------------------------------------
    // Answer after lat cycles
    // ----------------------------------------
    always @(posedge clk) begin
        ack <= 1'b0;
        rdata <= ~rdata;
        if (req && !ack) begin
            if (cnt >= lat) begin
                ack <= 1'b1;
                rdata <= mem.exists(addr) ? mem[addr] : 36'h0;
                n_req <= n_req + 1;
                last_addr <= addr;
                rar_seen <= read_alter_rewrite_cycle;
                cnt <= 0;
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the address modifier.
// Assumes mem_model and the bound checker; 50 ns clock.
`timescale 1ns/1ns
`default_nettype none

module testbench;
    logic clk = 0, rst_n = 0, start = 0, is_repeat = 0, privileged = 0;
    logic idx_we = 0, load_base_instruction = 0, done, busy, mem_req, mem_rar;
    logic mem_ack, direct_valid, tally_runout, tag_fault;
    logic [35:0] instr_word = 0, acc = 0, quot = 0, mem_rdata, mem_wdata;
    logic [35:0] direct_operand;
    logic [17:0] instruction_counter = 0, idx_wdata = 0, base_wdata = 0;
    logic [17:0] mem_addr, eff_addr, relocation_base, base_m, y, w, a;
    logic [17:0] xr_m [8];
    logic [11:0] tl, nt;
    logic [2:0] idx_waddr = 0, char_pos;
    logic [3:0] lat = 0;
    logic [31:0] seed = 32'h1;
    int fail_count = 0, checked = 0, nr;
    logic inc;

    always #25 clk = ~clk;

    addr_modifier i_dut (
        .clk(clk), .rst_n(rst_n), .start(start), .instr_word(instr_word),
        .is_repeat(is_repeat), .privileged(privileged),
        .instruction_counter(instruction_counter), .acc(acc), .quot(quot),
        .idx_we(idx_we), .idx_waddr(idx_waddr), .idx_wdata(idx_wdata),
        .load_base_instruction(load_base_instruction), .base_wdata(base_wdata),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_req(mem_req),
        .mem_rar(mem_rar), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .done(done), .eff_addr(eff_addr), .direct_valid(direct_valid),
        .direct_operand(direct_operand), .char_pos(char_pos),
        .tally_runout(tally_runout), .tag_fault(tag_fault), .busy(busy),
        .relocation_base(relocation_base)
    );

    mem_model i_mem (
        .clk(clk), .req(mem_req), .read_alter_rewrite_cycle(mem_rar), .addr(mem_addr), .lat(lat),
        .ack(mem_ack), .rdata(mem_rdata), .n_req(), .last_addr(), .rar_seen()
    );

    // ----------------------------------------
    // Reference model and helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [17:0] reloc(input logic [17:0] v);
        reloc = v;
        if (!privileged)
            reloc[17:9] = v[17:9] + base_m[17:9];
    endfunction

    function automatic logic [17:0] xidx(input logic [3:0] td);
        case (td)
            4'h1: xidx = acc[35:18];
            4'h2: xidx = quot[35:18];
            4'h4: xidx = instruction_counter;
            4'h5, 4'h6: xidx = acc[17:0];
            default: xidx = td[3] ? xr_m[td[2:0]] : 18'h0;
        endcase
    endfunction

    task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic run(input logic [35:0] iw, input logic rep);
        int n;
        @(negedge clk);
        instr_word = iw;
        is_repeat = rep;
        start = 1;
        @(negedge clk);
        start = 0;
        n = 0;
        while (done !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        chk("done", 1, done);
    endtask

    task automatic ld_base(input logic [17:0] v);
        @(negedge clk);
        base_wdata = v;
        load_base_instruction = 1;
        @(negedge clk);
        load_base_instruction = 0;
        base_m = v & 18'h3FDFE;
        chk("base", base_m, relocation_base);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #2000000;
        fail_count++;
        $display("BAD watchdog exp end got timeout");
        end_of_test();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1;
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            idx_we = 1;
            idx_waddr = 3'(i);
            idx_wdata = 18'(rnd());
            xr_m[i] = idx_wdata;
        end
        @(negedge clk);
        idx_we = 0;
        ld_base(18'(rnd()));
        ld_base(18'h3FFFF);
        $display("test base done");
        for (int p = 0; p < 2; p++) begin
            privileged = p[0];
            for (int td = 0; td < 16; td++) begin
                acc = 36'({rnd(), rnd()});
                quot = 36'({rnd(), rnd()});
                instruction_counter = 18'(rnd());
                y = 18'(rnd());
                nr = i_mem.n_req;
                run({y, 12'h0, 2'h0, 4'(td)}, 0);
                if (td == 3 || td == 7) begin
                    chk("dval", 1, direct_valid);
                    chk("dop", td == 3 ? {y, 18'h0} : {18'h0, y}, direct_operand);
                end else begin
                    chk("eff", reloc(y + xidx(4'(td))), eff_addr);
                end
                chk("nreq", nr, i_mem.n_req);
            end
        end
        privileged = 0;
        y = 18'(rnd());
        nr = i_mem.n_req;
        run({y, 12'h0, 6'h18}, 1);
        chk("eff", reloc(y), eff_addr);
        chk("nreq", nr, i_mem.n_req);
        $display("test register done");
        for (int k = 0; k < 3; k++) begin
            y = 18'(rnd());
            w = 18'(rnd());
            lat = 4'(k * 3);
            a = reloc(k == 0 ? y + xr_m[0] : y);
            i_mem.mem[a] = {w, 18'h0};
            run({y, 12'h0, k == 0 ? 6'h18 : k == 1 ? 6'h13 : 6'h31}, 0);
            chk("iaddr", a, i_mem.last_addr);
            chk("eff", reloc(k == 2 ? w + acc[35:18] : w), eff_addr);
        end
        $display("test indirect done");
        for (int k = 0; k < 4; k++) begin
            inc = !k[0];
            tl = k == 0 ? 12'h1 : k == 1 ? 12'hFFF : k == 2 ? 12'h5 : 12'h3;
            nt = inc ? tl - 12'h1 : tl + 12'h1;
            y = 18'(rnd());
            w = 18'(rnd());
            lat = 4'(rnd());
            i_mem.mem[reloc(y)] = {w, tl, 6'h00};
            run({y, 12'h0, 2'h2, (inc ? 4'hE : 4'hC) | 4'(k >> 1)}, 0);
            chk("eff", reloc(inc ? w : w - 18'h1), eff_addr);
            chk("wdata", {inc ? w + 18'h1 : w - 18'h1, nt, 6'h00}, mem_wdata);
            chk("runout", nt == 12'h0, tally_runout);
            chk("rar", 1, i_mem.rar_seen);
        end
        y = 18'(rnd());
        w = 18'(rnd());
        i_mem.mem[reloc(y)] = {w, 12'h5, 6'h05};
        run({y, 12'h0, 2'h2, 4'hA}, 0);
        chk("seq", {w + 18'h1, 3'h0}, {mem_wdata[35:18], mem_wdata[2:0]});
        i_mem.mem[reloc(y)] = {w, 12'h5, 6'h2A};
        run({y, 12'h0, 2'h2, 4'hB}, 0);
        chk("delta", w + 18'h2A, mem_wdata[35:18]);
        i_mem.mem[reloc(y)] = {w, 12'h5, 6'h03};
        run({y, 12'h0, 2'h2, 4'h8}, 0);
        chk("cpos", 3'h3, char_pos);
        chk("eff", reloc(w), eff_addr);
        chk("rar", 0, i_mem.rar_seen);
        run({y, 12'h0, 2'h2, 4'h9}, 0);
        chk("eff", reloc(w), eff_addr);
        chk("rar", 0, i_mem.rar_seen);
        run({y, 12'h0, 2'h2, 4'h0}, 0);
        chk("fault", 1, tag_fault);
        run({y, 12'h0, 6'h00}, 0);
        chk("fault", 0, tag_fault);
        $display("test tally done");
        end_of_test();
    end
endmodule
`default_nettype wire
